/* scsd_tick_div.sv */
// constants and types of the system clock select/divide block, plus the
// source tick divider; assumes source clocks arrive as one-cycle ticks on clk
`timescale 1ns/10ps

package scsd_pkg;
    // register byte addresses on the avalon slave
    localparam logic [3:0] ADDR_MODE   = 4'h0;
    localparam logic [3:0] ADDR_OSC    = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    // reset values: on-chip source, divide by 8
    localparam logic [3:0] MODE_RESET  = 4'hd;
    localparam logic       OSC_RESET   = 1'b0;
    // mode bit positions
    localparam int SRC_BIT  = 0;
    localparam int EXT_BIT  = 1;
    localparam int DIVL_BIT = 2;
    localparam int DIVH_BIT = 3;
    // last machine phase: instruction clock is system clock over this count plus one
    localparam logic [1:0] INSTR_DIV_LAST = 2'h2;

    typedef enum logic {SRC_EXT, SRC_ONCHIP} scsd_src_t;

    typedef struct packed {
        scsd_src_t  src;
        logic [1:0] ratio;   // 0:/1 1:/2 2:/4 3:/8
    } scsd_cfg_t;

    localparam scsd_cfg_t CFG_RESET = '{src: SRC_ONCHIP, ratio: 2'h3};
endpackage

module scsd_tick_div (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // source tick and ratio
    input  wire logic       tick_in,
    input  wire logic [1:0] ratio,
    input  wire logic       restart,
    // divided tick
    output logic            tick_out
);
    logic [2:0] count_q;
    logic [2:0] count_d;
    logic       tick_d;
    logic [2:0] limit;

    // last count of the divide window, 2^ratio - 1
    assign limit = 3'((4'h1 << ratio) - 4'h1);

    // count source ticks, emit one per window
    always_comb begin
        count_d = count_q;
        tick_d  = 1'b0;
        if (restart) begin
            count_d = 3'h0;
        end else if (tick_in) begin
            if (count_q >= limit) begin
                count_d = 3'h0;
                tick_d  = 1'b1;
            end else begin
                count_d = count_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_q  <= 3'h0;
            tick_out <= 1'b0;
        end else begin
            count_q  <= count_d;
            tick_out <= tick_d;
        end
    end

    chk_div_window: assert property (@(posedge clk) disable iff (srst)
        tick_out |-> $past(count_q) == $past(limit))
        else $error("divided tick outside window end");
endmodule

/* scsd_clock_select.sv */
// system clock source select and divider with instruction clock derivation
// assumes oscillator ticks are one-cycle pulses synchronous to clk and an
// avalon-mm master that holds its request until waitrequest is low
//
// Summary of operation
// - system clock from on-chip or external source
// - only mode and oscillator registers choose clock
// - mode bit0 and osc bit0 pick source
// - mode bits 3:2 divide by 1,2,4,8
// - reset selects on-chip source divided by 8
// - instruction clock is system clock over three
// - one instruction clock is one machine cycle
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/10ps

module scsd_clock_select (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // oscillator ticks
    input  wire logic        onchip_osc_tick,
    input  wire logic        ext_osc_tick,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // derived clocks
    output logic             system_clock_tick,
    output logic             instr_clock_tick,
    output logic [1:0]       machine_phase
);
    logic [3:0]       clock_mode_reg_q;
    logic [3:0]       clock_mode_reg_d;
    logic             oscillator_ctrl_reg_q;
    logic             oscillator_ctrl_reg_d;
    logic [31:0]      rdata_d;
    logic             wait_d;
    scsd_pkg::scsd_cfg_t act_q;
    scsd_pkg::scsd_cfg_t act_d;
    scsd_pkg::scsd_cfg_t want;
    logic             src_tick;
    logic             div_tick;
    logic             apply;
    logic [1:0]       phase_d;
    logic             instr_d;

    // decode registers into source and ratio
    function automatic scsd_pkg::scsd_cfg_t decode_cfg(
        input logic [3:0] mode,
        input logic       osc
    );
        scsd_pkg::scsd_cfg_t c;
        c.ratio = {mode[scsd_pkg::DIVH_BIT], mode[scsd_pkg::DIVL_BIT]};
        // on-chip only with osc bit clear; ext bit is don't-care there
        if (mode[scsd_pkg::SRC_BIT] && !osc) begin
            c.src = scsd_pkg::SRC_ONCHIP;
        end else begin
            c.src = scsd_pkg::SRC_EXT;
        end
        return c;
    endfunction

    assign want = decode_cfg(clock_mode_reg_q, oscillator_ctrl_reg_q);

    // bus: one wait cycle, then data and write land together
    always_comb begin
        clock_mode_reg_d      = clock_mode_reg_q;
        oscillator_ctrl_reg_d = oscillator_ctrl_reg_q;
        wait_d  = !((avs_read || avs_write) && avs_waitrequest);
        rdata_d = avs_readdata;
        if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
            unique case (avs_address)
                scsd_pkg::ADDR_MODE: clock_mode_reg_d = avs_writedata[3:0];
                scsd_pkg::ADDR_OSC:  oscillator_ctrl_reg_d = avs_writedata[0];
                default: ;  // status and unmapped ignore writes
            endcase
        end
        if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
                scsd_pkg::ADDR_MODE:
                    rdata_d = {28'h0, clock_mode_reg_q};
                scsd_pkg::ADDR_OSC:
                    rdata_d = {31'h0, oscillator_ctrl_reg_q};
                scsd_pkg::ADDR_STATUS:
                    rdata_d = {27'h0, machine_phase, act_q.ratio, act_q.src};
                default:
                    rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clock_mode_reg_q      <= scsd_pkg::MODE_RESET;
            oscillator_ctrl_reg_q <= scsd_pkg::OSC_RESET;
            avs_waitrequest       <= 1'b1;
            avs_readdata          <= 32'h0;
        end else begin
            clock_mode_reg_q      <= clock_mode_reg_d;
            oscillator_ctrl_reg_q <= oscillator_ctrl_reg_d;
            avs_waitrequest       <= wait_d;
            avs_readdata          <= rdata_d;
        end
    end

    // pick the active source tick
    assign src_tick = (act_q.src == scsd_pkg::SRC_ONCHIP) ?
                      onchip_osc_tick : ext_osc_tick;

    // swap config only as a divided tick completes, so no short pulse
    assign apply = div_tick && (act_q != want);

    scsd_tick_div u_div (
        .clk      (clk),
        .srst     (srst),
        .tick_in  (src_tick),
        .ratio    (act_q.ratio),
        .restart  (apply),
        .tick_out (div_tick)
    );

    // active config and instruction clock divider
    always_comb begin
        act_d   = apply ? want : act_q;
        phase_d = machine_phase;
        instr_d = 1'b0;
        if (div_tick) begin
            if (machine_phase == scsd_pkg::INSTR_DIV_LAST) begin
                phase_d = 2'h0;
                instr_d = 1'b1;
            end else begin
                phase_d = machine_phase + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            act_q             <= scsd_pkg::CFG_RESET;
            machine_phase     <= 2'h0;
            instr_clock_tick  <= 1'b0;
            system_clock_tick <= 1'b0;
        end else begin
            act_q             <= act_d;
            machine_phase     <= phase_d;
            instr_clock_tick  <= instr_d;
            system_clock_tick <= div_tick;
        end
    end

    // source tick, then divider tick in the next cycle
    sequence s_src_then_div;
        src_tick ##1 div_tick;
    endsequence

    // a request seen while waiting is answered in exactly one cycle
    sequence s_bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    // answer stands one cycle, then the slave waits again
    sequence s_bus_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_tick_from_src: assert property (
        @(posedge clk) disable iff (srst)
        system_clock_tick |-> $past(src_tick, 2))
        else $error("system tick without source tick");
    chk_cfg_only_regs: assert property (
        @(posedge clk) disable iff (srst)
        (act_q != $past(act_q)) |-> $past(want) == act_q)
        else $error("active config not from registers");
    chk_bus_answer: assert property (
        @(posedge clk) disable iff (srst)
        s_bus_req |=> s_bus_ack)
        else $error("bus answer not after one wait cycle");
    chk_mode_write: assert property (
        @(posedge clk) disable iff (srst)
        avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == scsd_pkg::ADDR_MODE
        |=> clock_mode_reg_q == $past(avs_writedata[3:0]))
        else $error("mode write did not land");
    chk_regs_held: assert property (
        @(posedge clk) disable iff (srst)
        !(avs_write && !avs_waitrequest)
        |=> $stable(clock_mode_reg_q) && $stable(oscillator_ctrl_reg_q))
        else $error("register changed without a write");
    chk_src_decode: assert property (
        @(posedge clk) disable iff (srst)
        apply |=> (act_q.src == scsd_pkg::SRC_ONCHIP)
        == $past(clock_mode_reg_q[0] && !oscillator_ctrl_reg_q))
        else $error("source decode wrong");
    chk_ratio_decode: assert property (
        @(posedge clk) disable iff (srst)
        apply |=> act_q.ratio == $past(clock_mode_reg_q[3:2]))
        else $error("ratio decode wrong");
    chk_reset_cfg: assert property (
        @(posedge clk)
        srst |=> act_q == scsd_pkg::CFG_RESET
        && clock_mode_reg_q == scsd_pkg::MODE_RESET
        && oscillator_ctrl_reg_q == scsd_pkg::OSC_RESET)
        else $error("reset config not on-chip over 8");
    chk_instr_div3: assert property (
        @(posedge clk) disable iff (srst)
        s_src_then_div ##1 (machine_phase == 2'h0)
        |-> $past(machine_phase, 1) == scsd_pkg::INSTR_DIV_LAST)
        else $error("instruction divide not by three");
    chk_phase_range: assert property (
        @(posedge clk) disable iff (srst)
        machine_phase != 2'h3)
        else $error("machine phase out of range");
    chk_machine_cycle: assert property (
        @(posedge clk) disable iff (srst)
        instr_clock_tick |-> system_clock_tick
        && machine_phase == 2'h0)
        else $error("machine cycle not aligned");
    chk_switch_edge: assert property (
        @(posedge clk) disable iff (srst)
        (act_q != $past(act_q)) |-> $past(div_tick))
        else $error("config switched mid period");
    // restart swallows the window, so no short pulse follows a swap
    chk_restart_swap: assert property (
        @(posedge clk) disable iff (srst)
        apply |=> !div_tick)
        else $error("divided tick right after a swap");
endmodule

/* system_clock_select_divider_tb.sv */
// self-checking bench for the system clock select/divide block
// assumes scsd_pkg is compiled first; oscillator ticks made here on clk
`timescale 1ns/10ps

module system_clock_select_divider_tb;
    logic        clk             = 1'b0;
    logic        srst            = 1'b1;
    logic        onchip_osc_tick = 1'b0;
    logic        ext_osc_tick    = 1'b0;
    logic [3:0]  avs_address     = 4'h0;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [3:0]  avs_byteenable  = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        system_clock_tick;
    logic        instr_clock_tick;
    logic [1:0]  machine_phase;
    int          err_total       = 0;
    int          n_compared      = 0;
    int          oc              = 0;
    int          ec              = 0;

    scsd_clock_select u_dut (.clk(clk), .srst(srst),
        .onchip_osc_tick(onchip_osc_tick), .ext_osc_tick(ext_osc_tick),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .system_clock_tick(system_clock_tick),
        .instr_clock_tick(instr_clock_tick), .machine_phase(machine_phase));

    initial begin
        forever #25 clk = ~clk;
    end
    // on-chip source every 3 cycles, external every 2: periods differ
    always @(posedge clk) begin
        oc <= (oc == 2) ? 0 : oc + 1;
        ec <= (ec == 1) ? 0 : ec + 1;
        onchip_osc_tick <= (oc == 0);
        ext_osc_tick <= (ec == 0);
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask
    // cycles between two system ticks; the watchdog bounds a stuck wait
    task automatic per(output int p);
        p = 0;
        while (system_clock_tick !== 1'b1) begin
            @(posedge clk);
        end
        do begin
            @(posedge clk);
            p++;
        end while (system_clock_tick !== 1'b1);
    endtask
    // third period: the change lands only at a window end
    task automatic setp(input logic [3:0] m, input int exp);
        int p;
        wr(scsd_pkg::ADDR_MODE, {28'h0, m});
        per(p);
        per(p);
        per(p);
        chk("period", 32'(p), 32'(exp));
    endtask

    task automatic t_reset;
        logic [31:0] q;
        int p;
        bus(1'b0, scsd_pkg::ADDR_MODE, 32'h0, 4'hf, q);
        chk("mode", q, 32'hd);
        bus(1'b0, scsd_pkg::ADDR_OSC, 32'h0, 4'hf, q);
        chk("osc", q, 32'h0);
        bus(1'b0, scsd_pkg::ADDR_STATUS, 32'h0, 4'hf, q);
        chk("status", {29'h0, q[2:0]}, 32'h7);
        per(p);
        per(p);
        chk("reset period", 32'(p), 32'd24);
        $display("test reset done");
    endtask
    task automatic t_ratio;
        for (int r = 0; r < 4; r++) begin
            setp({2'(r), 2'b00}, 2 << r);
            setp({2'(r), 2'b01}, 3 << r);
        end
        $display("test ratio done");
    endtask
    task automatic t_select;
        logic [31:0] q;
        setp(4'h3, 3);
        wr(scsd_pkg::ADDR_OSC, 32'h1);
        setp(4'h0, 2);
        bus(1'b0, scsd_pkg::ADDR_STATUS, 32'h0, 4'hf, q);
        chk("status src", {31'h0, q[0]}, 32'h0);
        wr(scsd_pkg::ADDR_OSC, 32'h0);
        $display("test select done");
    endtask
    // system ticks and cycles per instruction tick
    task automatic t_instr;
        int s;
        int c;
        setp(4'h1, 3);
        s = 0;
        c = 0;
        while (instr_clock_tick !== 1'b1) begin
            @(posedge clk);
        end
        do begin
            @(posedge clk);
            c++;
            if (system_clock_tick === 1'b1) begin
                s++;
                chk("phase", 32'(machine_phase), 32'(s % 3));
            end
        end while (instr_clock_tick !== 1'b1);
        chk("sys per instr", 32'(s), 32'd3);
        chk("machine cycle", 32'(c), 32'd9);
        $display("test instr done");
    endtask
    task automatic t_refuse;
        logic [31:0] q;
        bus(1'b1, scsd_pkg::ADDR_MODE, 32'hc, 4'h0, q);
        wr(scsd_pkg::ADDR_STATUS, 32'h0);
        bus(1'b0, 4'hc, 32'h0, 4'hf, q);
        chk("unmapped", q, 32'h0);
        bus(1'b0, scsd_pkg::ADDR_MODE, 32'h0, 4'hf, q);
        chk("mode kept", q, 32'h1);
        $display("test refuse done");
    endtask
    // reset again after the registers were changed
    task automatic t_rereset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        $display("test mid-run reset done");
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog far beyond the expected run of under a thousand cycles
    initial begin
        #1000000;
        err_total++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_ratio;
        t_select;
        t_instr;
        t_refuse;
        t_rereset;
        stop_test;
    end
endmodule
